// ==== logic/sfs_pkg.sv ====
//------------------------------------------------------------
//------------------------------------------------------------
package sfs_pkg;
  // timebase
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SIMUL_OFS = 8'h04;
  localparam logic [7:0] DELAY_OFS = 8'h08;
  localparam logic [7:0] PULSE_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] LUT_OFS = 8'h40;
  // control fields
  localparam int unsigned DEP_POL_BIT = 0;
  localparam int unsigned IND_POL_BIT = 1;
  localparam int unsigned DLY_OFF_BIT = 2;
  localparam int unsigned EDGE_FALL_BIT = 3;
  localparam int unsigned ERR_REQ_BIT = 4;
  localparam int unsigned SEL_CNT_LSB = 8;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0800;
  localparam logic [15:0] SIMUL_RST = 16'h01F4;
  localparam logic [15:0] DELAY_RST = 16'h03E8;
  localparam logic [15:0] PULSE_RST = 16'h0064;

  // field contacts, raw or filtered
  typedef struct packed {
    logic [7:0] sel;
    logic ind_b;
    logic ind_a;
    logic dep_b;
    logic dep_a;
    logic stat;
    logic single;
  } sfs_field_t;

  // monitor results
  typedef struct packed {
    logic [3:0] sel_val;
    logic sel_err;
    logic ind_err;
    logic ind_ok;
    logic dep_err;
    logic dep_ok;
    logic stat_ok;
    logic single_err;
    logic single_ok;
  } sfs_mon_t;

  // function results
  typedef struct packed {
    logic start;
    logic pulse;
    logic delay;
    logic nor_out;
    logic or_out;
    logic and_out;
  } sfs_fn_t;

  typedef enum logic [2:0] {
    DP_IDLE = 3'b001,
    DP_SKEW = 3'b010,
    DP_FAIL = 3'b100
  } sfs_dp_st_t;
endpackage

// ==== logic/sfs_top.sv ====
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module sfs_top #(
  parameter int unsigned TICK_CYCLES = sfs_pkg::TICK_CYC,
  parameter int unsigned LUT_ENTRIES = 9,
  parameter int unsigned LUT_W = 4
) (
  input wire logic clk_i, // 10 MHz
  input wire logic rst_n_i, // sync reset
  input wire sfs_pkg::sfs_field_t field_i, // raw contacts
  input wire sfs_pkg::sfs_field_t fault_i, // raw per-input faults
  input wire logic module_fault_i, // raw internal fault
  input wire logic [7:0] addr_i, // register address
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [15:0] rdata_o, // read data
  output sfs_pkg::sfs_mon_t mon_o, // monitor results
  output sfs_pkg::sfs_fn_t safety_o, // safety outputs
  output logic [LUT_W-1:0] lut_o, // converted value out
  output logic error_state_o // module in error
);
  import sfs_pkg::*;

  // refuse sizes that the counters, decode and status word cannot serve
  if (TICK_CYCLES < 1 || LUT_ENTRIES < 1 || LUT_ENTRIES > 16 || LUT_W < 1 || LUT_W > 16) begin : g_param_chk
    $error("sfs_top: unsupported parameters");
  end

  // one-hot position -> 1..8, 0 when not exactly one
  function automatic logic [3:0] pos_value(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v == 8'(1 << i)) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction

  //------------------------------------------------------------
  // input filtering
  //------------------------------------------------------------
  logic [28:0] s1_reg, s2_reg, s3_reg, filt_reg;
  sfs_field_t fin, ffl;
  logic mfault;

  // three stages; accept once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= {module_fault_i, fault_i, field_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 29; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  assign fin = filt_reg[13:0];
  assign ffl = filt_reg[27:14];
  assign mfault = filt_reg[28];

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [15:0] ctrl_reg, simul_reg, delay_reg, pulse_reg;
  logic [LUT_W-1:0] lut_reg [LUT_ENTRIES];
  logic err_reg;
  logic [3:0] sel_cnt;
  assign sel_cnt = ctrl_reg[SEL_CNT_LSB +: 4];
  logic [15:0] lut_ext;
  // status shows only the low four bits of the converted value
  assign lut_ext = 16'(lut_o);

  // software writes; position count clamped to 2..8
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
      simul_reg <= SIMUL_RST;
      delay_reg <= DELAY_RST;
      pulse_reg <= PULSE_RST;
      for (int i = 0; i < LUT_ENTRIES; i++) begin
        lut_reg[i] <= '0;
      end
    end else if (wr_i) begin
      unique case (addr_i)
        CTRL_OFS: begin
          ctrl_reg <= wdata_i & 16'h0F0F; // error request bit is not stored
          if (wdata_i[11:8] < 4'h2) begin
            ctrl_reg[SEL_CNT_LSB +: 4] <= 4'h2;
          end else if (wdata_i[11:8] > 4'h8) begin
            ctrl_reg[SEL_CNT_LSB +: 4] <= 4'h8;
          end
        end
        SIMUL_OFS: simul_reg <= wdata_i;
        DELAY_OFS: delay_reg <= wdata_i;
        PULSE_OFS: pulse_reg <= wdata_i;
        default: begin
          for (int i = 0; i < LUT_ENTRIES; i++) begin
            if (addr_i == LUT_OFS + 8'(4 * i)) begin
              lut_reg[i] <= wdata_i[LUT_W-1:0];
            end
          end
        end
      endcase
    end
  end

  // read data for one cycle only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        unique case (addr_i)
          CTRL_OFS: rdata_o <= ctrl_reg;
          SIMUL_OFS: rdata_o <= simul_reg;
          DELAY_OFS: rdata_o <= delay_reg;
          PULSE_OFS: rdata_o <= pulse_reg;
          STATUS_OFS: rdata_o <= 16'({1'b0, err_reg, 2'b00, lut_ext[3:0], safety_o});
          default: begin
            for (int i = 0; i < LUT_ENTRIES; i++) begin
              if (addr_i == LUT_OFS + 8'(4 * i)) begin
                rdata_o <= 16'(lut_reg[i]);
              end
            end
          end
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // error state and timebase
  //------------------------------------------------------------
  // sticky until reset; only rst_n_i clears it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_reg <= 1'b0;
    end else if (mfault || (wr_i && addr_i == CTRL_OFS && wdata_i[ERR_REQ_BIT])) begin
      err_reg <= 1'b1;
    end
  end
  assign error_state_o = err_reg;

  logic [$clog2(TICK_CYCLES+1)-1:0] tb_reg;
  logic tick;
  assign tick = (tb_reg == '0);
  // one tick pulse per timebase period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick) begin
      tb_reg <= ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1);
    end else begin
      tb_reg <= tb_reg - 1'b1;
    end
  end

  //------------------------------------------------------------
  // sensor monitors
  //------------------------------------------------------------
  logic dep_na, dep_nb, ind_na, ind_nb, dep_flt, ind_flt;
  logic [7:0] sel_mask, sel_act;
  // safe level per contact: a is always NC, b is NO when polarity set
  assign dep_na = fin.dep_a;
  assign dep_nb = ctrl_reg[DEP_POL_BIT] ? !fin.dep_b : fin.dep_b;
  assign ind_na = fin.ind_a;
  assign ind_nb = ctrl_reg[IND_POL_BIT] ? !fin.ind_b : fin.ind_b;
  assign dep_flt = ffl.dep_a | ffl.dep_b;
  assign ind_flt = ffl.ind_a | ffl.ind_b;
  assign sel_mask = 8'((9'h001 << sel_cnt) - 9'h001);
  assign sel_act = fin.sel & sel_mask;

  sfs_dp_st_t dp_reg;
  logic [15:0] skew_reg;
  // skew watch: both must reach the same level within the limit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dp_reg <= DP_IDLE;
      skew_reg <= '0;
    end else if (!err_reg) begin
      unique case (dp_reg)
        DP_IDLE: begin
          skew_reg <= '0;
          if (dep_na != dep_nb) begin
            dp_reg <= DP_SKEW;
          end
        end
        DP_SKEW: begin
          if (dep_na == dep_nb) begin
            dp_reg <= DP_IDLE;
          end else if (tick && skew_reg >= simul_reg) begin
            dp_reg <= DP_FAIL;
          end else if (tick) begin
            skew_reg <= skew_reg + 16'h0001;
          end
        end
        DP_FAIL: begin
          if (!dep_na && !dep_nb) begin
            dp_reg <= DP_IDLE; // cleared once both leave safe state
          end
        end
        default: dp_reg <= DP_FAIL;
      endcase
    end
  end

  // monitor outputs, frozen in error state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mon_o <= '0;
    end else if (!err_reg) begin
      mon_o.single_ok <= fin.single && !ffl.single;
      mon_o.single_err <= ffl.single;
      mon_o.stat_ok <= fin.stat;
      mon_o.dep_ok <= dep_na && dep_nb && !dep_flt && dp_reg != DP_FAIL;
      mon_o.dep_err <= dep_flt || dp_reg == DP_FAIL;
      mon_o.ind_ok <= ind_na && ind_nb && !ind_flt;
      mon_o.ind_err <= ind_flt;
      mon_o.sel_err <= pos_value(sel_act) == 4'h0 || |(ffl.sel & sel_mask);
      mon_o.sel_val <= |(ffl.sel & sel_mask) ? 4'h0 : pos_value(sel_act);
    end
  end

  //------------------------------------------------------------
  // logic functions
  //------------------------------------------------------------
  sfs_fn_t fn_reg;
  logic [3:0] srcs;
  logic [15:0] dcnt_reg, pcnt_reg;
  logic pin_reg, ctl_reg, ctl_edge;
  assign srcs = {mon_o.ind_ok, mon_o.dep_ok, mon_o.stat_ok, mon_o.single_ok};
  assign ctl_edge = ctrl_reg[EDGE_FALL_BIT] ? (ctl_reg && !mon_o.stat_ok)
                                            : (!ctl_reg && mon_o.stat_ok);

  // gates over the four monitor results
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fn_reg.and_out <= 1'b0;
      fn_reg.or_out <= 1'b0;
      fn_reg.nor_out <= 1'b0;
    end else if (!err_reg) begin
      fn_reg.and_out <= &srcs;
      fn_reg.or_out <= |srcs;
      fn_reg.nor_out <= ~|srcs;
    end
  end

  // delay on dependent pair result; reversal restarts the count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fn_reg.delay <= 1'b0;
      dcnt_reg <= '0;
    end else if (!err_reg) begin
      if (mon_o.dep_ok == fn_reg.delay) begin
        dcnt_reg <= '0;
      end else if (!ctrl_reg[DLY_OFF_BIT] && !mon_o.dep_ok) begin
        fn_reg.delay <= 1'b0;
        dcnt_reg <= '0;
      end else if (ctrl_reg[DLY_OFF_BIT] && mon_o.dep_ok) begin
        fn_reg.delay <= 1'b1;
        dcnt_reg <= '0;
      end else if (dcnt_reg >= delay_reg) begin
        fn_reg.delay <= mon_o.dep_ok;
        dcnt_reg <= '0;
      end else if (tick) begin
        dcnt_reg <= dcnt_reg + 16'h0001;
      end
    end
  end

  // pulse on falling edge of single contact result
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fn_reg.pulse <= 1'b0;
      pcnt_reg <= '0;
      pin_reg <= 1'b0;
    end else if (!err_reg) begin
      pin_reg <= mon_o.single_ok;
      if (pin_reg && !mon_o.single_ok) begin
        fn_reg.pulse <= 1'b1;
        pcnt_reg <= '0;
      end else if (fn_reg.pulse && pcnt_reg >= pulse_reg) begin
        fn_reg.pulse <= 1'b0;
      end else if (fn_reg.pulse && tick) begin
        pcnt_reg <= pcnt_reg + 16'h0001;
      end
    end
  end

  // start: main is independent pair, control is static monitor
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fn_reg.start <= 1'b0;
      ctl_reg <= 1'b0;
    end else if (!err_reg) begin
      ctl_reg <= mon_o.stat_ok;
      if (!mon_o.ind_ok) begin
        fn_reg.start <= 1'b0;
      end else if (ctl_edge) begin
        fn_reg.start <= 1'b1;
      end
    end
  end

  // lookup of selector value
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lut_o <= '0;
    end else if (!err_reg) begin
      lut_o <= '0;
      for (int i = 0; i < LUT_ENTRIES; i++) begin
        if (mon_o.sel_val == 4'(i)) begin
          lut_o <= lut_reg[i];
        end
      end
    end
  end

  // safety outputs open in error state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || err_reg) begin
      safety_o <= '0;
    end else begin
      safety_o <= fn_reg;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  single_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mon_o.single_ok |-> $past(fin.single && !ffl.single))
    else $error("single ok without closed clean contact");
  sel_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mon_o.sel_err |-> mon_o.sel_val == 4'h0)
    else $error("selector value not zero on error");
  and_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !err_reg |=> fn_reg.and_out == &$past(srcs))
    else $error("and output wrong");
  nor_or_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fn_reg.nor_out |-> !fn_reg.or_out)
    else $error("nor and or both high");
  err_open_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    err_reg |=> safety_o == '0)
    else $error("safety outputs not open in error");
  pulse_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(fn_reg.pulse) |-> $past(pin_reg && !mon_o.single_ok))
    else $error("pulse without falling edge");
  start_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!err_reg && !mon_o.ind_ok) |=> !fn_reg.start)
    else $error("start held without main input");
  on_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(fn_reg.delay) && !$past(ctrl_reg[DLY_OFF_BIT])) |-> $past(mon_o.dep_ok))
    else $error("on-delay rose without input");
  fail_err_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (dp_reg == DP_FAIL && !err_reg) |=> mon_o.dep_err && !mon_o.dep_ok)
    else $error("skew fault not flagged");
  stat_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !err_reg |=> mon_o.stat_ok == $past(fin.stat))
    else $error("static output not following input");
  ind_err_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !err_reg |=> mon_o.ind_err == $past(ind_flt))
    else $error("independent error not following faults");
endmodule // sfs_top
`default_nettype wire

// ==== sim/sfs_field_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// field contacts and sensors
// ------------------------------------------------------------
module sfs_field_model (
  input wire logic clk_i, // system clock
  input wire sfs_pkg::sfs_field_t want_i, // commanded contact levels
  input wire sfs_pkg::sfs_field_t want_fault_i, // commanded wiring faults
  output sfs_pkg::sfs_field_t field_o, // contact levels at the pins
  output sfs_pkg::sfs_field_t fault_o // fault flags at the pins
);
  import sfs_pkg::*;
  // contacts move only on the rising clock edge, as registered copies
  always_ff @(posedge clk_i) begin
    field_o <= want_i;
    fault_o <= want_fault_i;
  end
endmodule // sfs_field_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sfs_pkg::*;
  logic clk_i = 1'h0, rst_n_i = 1'h0, module_fault_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o, d;
  sfs_field_t want = '0, want_flt = '0, field_w, fault_w;
  sfs_mon_t mon_o;
  sfs_fn_t safety_o;
  logic [3:0] lut_o;
  logic error_state_o;
  int bad_count = 0, tests_run = 0, n;
  // ------------------------------------------------------------
  // design and field
  // ------------------------------------------------------------
  sfs_top #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .field_i(field_w),
    .fault_i(fault_w), .module_fault_i(module_fault_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mon_o(mon_o), .safety_o(safety_o),
    .lut_o(lut_o), .error_state_o(error_state_o));
  sfs_field_model field_u (.clk_i(clk_i), .want_i(want), .want_fault_i(want_flt),
    .field_o(field_w), .fault_o(fault_w));
  // 100 ns clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic go(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic c1(input string nm, input logic seen, input logic exp);
    check(nm, {15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    rst_n_i <= 1'h0;
    module_fault_i <= 1'h0;
    go(4);
    rst_n_i <= 1'h1;
    go(1);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    c1("lut_rst", lut_o == 4'h0, 1'h1);
    rd(CTRL_OFS);
    check("ctrl", d, CTRL_RST);
    rd(SIMUL_OFS);
    check("simul", d, SIMUL_RST);
    rd(DELAY_OFS);
    check("delay_rst", d, DELAY_RST);
    rd(PULSE_OFS);
    check("pulse_rst", d, PULSE_RST);
    rd(8'h20);
    check("unmapped", d, 16'h0000);
    wr(SIMUL_OFS, 16'h0003);
    wr(DELAY_OFS, 16'h0003);
    wr(PULSE_OFS, 16'h0002);
    for (int k = 0; k < 9; k++) wr(LUT_OFS + 8'(4 * k), 16'(15 - k));
    rd(DELAY_OFS);
    check("delay_wr", d, 16'h0003);
    $display("test regs done");
  endtask
  task automatic t_single;
    want.single = 1'h1;
    want.stat = 1'h1;
    go(12);
    c1("single_ok", mon_o.single_ok, 1'h1);
    c1("stat_ok", mon_o.stat_ok, 1'h1);
    want_flt.single = 1'h1;
    want.stat = 1'h0;
    go(12);
    c1("single_ok_flt", mon_o.single_ok, 1'h0);
    c1("single_err", mon_o.single_err, 1'h1);
    c1("stat_low", mon_o.stat_ok, 1'h0);
    want_flt.single = 1'h0;
    want.single = 1'h0;
    go(12);
    c1("single_err_clr", mon_o.single_err, 1'h0);
    $display("test single done");
  endtask
  task automatic t_logic;
    for (int i = 0; i < 16; i++) begin
      want.single = i[0];
      want.stat = i[1];
      want.dep_a = i[2];
      want.dep_b = i[2];
      want.ind_a = i[3];
      want.ind_b = i[3];
      go(14);
      c1("and", safety_o.and_out, i == 15);
      c1("or", safety_o.or_out, i != 0);
      c1("nor", safety_o.nor_out, i == 0);
    end
    want = '0;
    go(14);
    $display("test logic done");
  endtask
  task automatic t_pairs;
    want.dep_a = 1'h1;
    want.ind_a = 1'h1;
    go(30);
    c1("dep_skew_err", mon_o.dep_err, 1'h1);
    c1("ind_no_skew", mon_o.ind_err, 1'h0);
    want.dep_b = 1'h1;
    go(12);
    c1("dep_ok_err", mon_o.dep_ok, 1'h0);
    want.dep_a = 1'h0;
    want.dep_b = 1'h0;
    go(12);
    c1("dep_err_clr", mon_o.dep_err, 1'h0);
    wr(CTRL_OFS, 16'h0803);
    want.dep_a = 1'h1;
    want.ind_b = 1'h0;
    go(12);
    c1("dep_ok_nonc", mon_o.dep_ok, 1'h1);
    c1("ind_ok_nonc", mon_o.ind_ok, 1'h1);
    want_flt.ind_b = 1'h1;
    want_flt.dep_b = 1'h1;
    go(12);
    c1("ind_err", mon_o.ind_err, 1'h1);
    c1("ind_ok_flt", mon_o.ind_ok, 1'h0);
    c1("dep_err_flt", mon_o.dep_err, 1'h1);
    want_flt = '0;
    want = '0;
    wr(CTRL_OFS, 16'h0800);
    go(12);
    $display("test pairs done");
  endtask
  task automatic t_sel;
    for (int i = 0; i < 8; i++) begin
      want.sel = 8'h01 << i;
      go(12);
      check("sel_val", {12'h000, mon_o.sel_val}, 16'(i + 1));
      c1("sel_err", mon_o.sel_err, 1'h0);
      check("lut", {12'h000, lut_o}, 16'(14 - i));
    end
    want.sel = 8'h00;
    go(12);
    c1("sel_none", mon_o.sel_err, 1'h1);
    check("sel_none_val", {12'h000, mon_o.sel_val}, 16'h0000);
    check("lut_zero", {12'h000, lut_o}, 16'h000f);
    want.sel = 8'h03;
    go(12);
    c1("sel_many", mon_o.sel_err, 1'h1);
    wr(CTRL_OFS, 16'h0300);
    want.sel = 8'h20;
    go(12);
    c1("sel_outside", mon_o.sel_err, 1'h1);
    want.sel = 8'h04;
    go(12);
    check("sel_cnt3", {12'h000, mon_o.sel_val}, 16'h0003);
    want_flt.sel = 8'h04;
    go(12);
    c1("sel_flt", mon_o.sel_err, 1'h1);
    want_flt = '0;
    want.sel = 8'h00;
    wr(CTRL_OFS, 16'h0800);
    $display("test selector done");
  endtask
  task automatic t_delay;
    want.dep_a = 1'h1;
    want.dep_b = 1'h1;
    go(10);
    c1("on_early", safety_o.delay, 1'h0);
    go(25);
    c1("on_late", safety_o.delay, 1'h1);
    wr(CTRL_OFS, 16'h0804);
    want.dep_a = 1'h0;
    want.dep_b = 1'h0;
    go(10);
    c1("off_early", safety_o.delay, 1'h1);
    go(25);
    c1("off_late", safety_o.delay, 1'h0);
    wr(CTRL_OFS, 16'h0800);
    want.dep_a = 1'h1;
    want.dep_b = 1'h1;
    go(6);
    want.dep_a = 1'h0;
    want.dep_b = 1'h0;
    go(30);
    c1("on_cancel", safety_o.delay, 1'h0);
    $display("test delay done");
  endtask
  task automatic t_pulse;
    want.single = 1'h1;
    go(12);
    c1("pulse_idle", safety_o.pulse, 1'h0);
    want.single = 1'h0;
    n = 0;
    repeat (40) begin
      go(1);
      if (safety_o.pulse === 1'h1) n++;
    end
    c1("pulse_len", n >= 4 && n <= 12, 1'h1);
    $display("test pulse done");
  endtask
  task automatic t_start;
    want.ind_a = 1'h1;
    want.ind_b = 1'h1;
    go(12);
    want.stat = 1'h1;
    go(12);
    c1("start_rise", safety_o.start, 1'h1);
    want.ind_a = 1'h0;
    want.ind_b = 1'h0;
    go(12);
    c1("start_drop", safety_o.start, 1'h0);
    want.stat = 1'h0;
    go(12);
    want.stat = 1'h1;
    go(12);
    c1("start_no_main", safety_o.start, 1'h0);
    wr(CTRL_OFS, 16'h0808);
    want.ind_a = 1'h1;
    want.ind_b = 1'h1;
    go(12);
    c1("start_no_edge", safety_o.start, 1'h0);
    want.stat = 1'h0;
    go(12);
    c1("start_fall", safety_o.start, 1'h1);
    wr(CTRL_OFS, 16'h0800);
    $display("test start done");
  endtask
  task automatic t_error;
    want.stat = 1'h1;
    go(12);
    wr(CTRL_OFS, 16'h0F10);
    go(4);
    c1("err_req", error_state_o, 1'h1);
    check("err_safe", {10'h000, safety_o}, 16'h0000);
    rd(CTRL_OFS);
    check("ctrl_clamp", d, CTRL_RST);
    rd(STATUS_OFS);
    check("status", d, 16'h13C0);
    want.stat = 1'h0;
    go(12);
    c1("err_frozen", mon_o.stat_ok, 1'h1);
    want = '0;
    do_reset();
    c1("err_rst", error_state_o, 1'h0);
    module_fault_i <= 1'h1;
    go(8);
    module_fault_i <= 1'h0;
    go(8);
    c1("err_sticky", error_state_o, 1'h1);
    check("err_safe2", {10'h000, safety_o}, 16'h0000);
    $display("test error done");
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    go(2);
    rst_n_i <= 1'h1;
    go(1);
    t_regs();
    t_single();
    t_logic();
    t_pairs();
    t_sel();
    t_delay();
    t_pulse();
    t_start();
    t_error();
    wrap_up();
  end
  // cut a hang short well past the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
